// *** include/sktf_regs.vh ***
// register map, field positions, reset values and opcodes of the skip-test block
`ifndef SKTF_REGS_VH
`define SKTF_REGS_VH
`define SKTF_OFS_INTCTL2 4'h0
`define SKTF_OFS_EXT0CTL 4'h4
`define SKTF_OFS_EXT1CTL 4'h8
`define SKTF_OFS_STATUS 4'hc
`define SKTF_CTL_RST 4'h0
`define SKTF_BIT_CONV_IE 2
`define SKTF_BIT_POL 2
`define SKTF_ST_CONV_FLAG 0
`define SKTF_ST_PIN0 1
`define SKTF_ST_PIN1 2
`define SKTF_ST_SKIP 3
`define SKTF_OP_CONV_DONE 10'h287
`define SKTF_OP_EXT0_LEVEL 10'h03a
`define SKTF_OP_EXT1_LEVEL 10'h03b
`define SKTF_RESP_OKAY 2'h0
`define SKTF_RESP_SLVERR 2'h2
`endif

// *** verilog/sktf_sync.v ***
// two-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ns
module sktf_sync #(
  parameter WIDTH = 2
) (
  input wire mclk,
  input wire sys_rst,
  input wire [WIDTH-1:0] async_i,
  output reg [WIDTH-1:0] sync_o
);
  reg [WIDTH-1:0] meta_q;

  // first stage feeds only the second stage
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_q <= {WIDTH{1'b0}};
      sync_o <= {WIDTH{1'b0}};
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule // sktf_sync

// *** verilog/sktf_core.v ***
// skip-test decoder for conversion-done flag and external pin levels, with AXI4-Lite registers
`timescale 1ns/1ns
`include "sktf_regs.vh"
module sktf_core (
  input wire mclk,
  input wire sys_rst,
  input wire instr_valid,
  input wire [9:0] instr_word,
  input wire conv_done_set,
  input wire external_input_zero_pin,
  input wire external_input_one_pin,
  output reg instr_done,
  output reg skip_next,
  output reg conversion_done_flag,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);
  reg [3:0] interrupt_control_second_q;
  reg [3:0] ext0_interrupt_control_q;
  reg [3:0] ext1_interrupt_control_q;
  reg [3:0] awaddr_q;
  reg aw_held_q;
  reg [3:0] wdata_q;
  reg w_held_q;
  wire [1:0] pin_sync;
  wire conversion_irq_enable_bit;
  wire ext0_level_polarity_bit;
  wire ext1_level_polarity_bit;
  wire exec;
  wire op_conv;
  wire op_ext0;
  wire op_ext1;
  wire skip_conv;
  wire skip_ext0;
  wire skip_ext1;
  wire do_write;
  wire sw_clear_flag;
  wire [3:0] status;

  // returns 1 for any address inside the 16-byte register window; addresses above it give 0
  function [1:0] reg_hit;
    input [31:0] addr;
    begin
      reg_hit = 2'h0;
      if (addr[31:4] == 28'h0) begin
        reg_hit = 2'h1;
      end
    end
  endfunction

  sktf_sync #(
    .WIDTH(2)
  ) u_pin_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .async_i({external_input_one_pin, external_input_zero_pin}),
    .sync_o(pin_sync)
  );

  assign conversion_irq_enable_bit = interrupt_control_second_q[`SKTF_BIT_CONV_IE];
  assign ext0_level_polarity_bit = ext0_interrupt_control_q[`SKTF_BIT_POL];
  assign ext1_level_polarity_bit = ext1_interrupt_control_q[`SKTF_BIT_POL];

  // an instruction arriving while a skip is pending is the skipped one and is dropped
  assign exec = instr_valid & ~skip_next;
  assign op_conv = exec & (instr_word == `SKTF_OP_CONV_DONE);
  assign op_ext0 = exec & (instr_word == `SKTF_OP_EXT0_LEVEL);
  assign op_ext1 = exec & (instr_word == `SKTF_OP_EXT1_LEVEL);
  // with the enable set the test is a no-operation
  assign skip_conv = op_conv & ~conversion_irq_enable_bit & conversion_done_flag;
  // polarity 0 skips on low, polarity 1 skips on high
  assign skip_ext0 = op_ext0 & ~(pin_sync[0] ^ ext0_level_polarity_bit);
  assign skip_ext1 = op_ext1 & ~(pin_sync[1] ^ ext1_level_polarity_bit);

  assign do_write = aw_held_q & w_held_q & ~s_axi_bvalid;
  assign sw_clear_flag = do_write & (reg_hit({28'h0, awaddr_q}) == 2'h1) &
    (awaddr_q == `SKTF_OFS_STATUS) & wdata_q[`SKTF_ST_CONV_FLAG];
  assign status = {skip_next, pin_sync[1], pin_sync[0], conversion_done_flag};

  // sequencer side: one-cycle completion, skip indication held until next fetch
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      instr_done <= 1'b0;
      skip_next <= 1'b0;
    end else begin
      instr_done <= op_conv | op_ext0 | op_ext1;
      if (skip_conv | skip_ext0 | skip_ext1) begin
        skip_next <= 1'b1;
      end else if (instr_valid) begin
        skip_next <= 1'b0;
      end
    end
  end

  // set wins over both the skip clear and the software clear
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      conversion_done_flag <= 1'b0;
    end else if (conv_done_set) begin
      conversion_done_flag <= 1'b1;
    end else if (skip_conv | sw_clear_flag) begin
      conversion_done_flag <= 1'b0;
    end
  end

  // write path: address and data accepted in either order, response once both are held
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 4'h0;
      wdata_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SKTF_RESP_OKAY;
      interrupt_control_second_q <= `SKTF_CTL_RST;
      ext0_interrupt_control_q <= `SKTF_CTL_RST;
      ext1_interrupt_control_q <= `SKTF_CTL_RST;
    end else begin
      s_axi_awready <= ~aw_held_q & ~(s_axi_awvalid & s_axi_awready);
      s_axi_wready <= ~w_held_q & ~(s_axi_wvalid & s_axi_wready);
      if (s_axi_awvalid & s_axi_awready) begin
        aw_held_q <= 1'b1;
        // out-of-range addresses are folded so the decode below refuses them
        awaddr_q <= (s_axi_awaddr[31:4] == 28'h0 && s_axi_awaddr[1:0] == 2'h0) ?
          s_axi_awaddr[3:0] : 4'h1;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wstrb[0] ? s_axi_wdata[3:0] : 4'h0;
      end
      if (do_write) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `SKTF_RESP_OKAY;
        case (awaddr_q)
          `SKTF_OFS_INTCTL2: begin
            interrupt_control_second_q <= wdata_q;
          end
          `SKTF_OFS_EXT0CTL: begin
            ext0_interrupt_control_q <= wdata_q;
          end
          `SKTF_OFS_EXT1CTL: begin
            ext1_interrupt_control_q <= wdata_q;
          end
          `SKTF_OFS_STATUS: begin
            s_axi_bresp <= `SKTF_RESP_OKAY;
          end
          default: begin
            s_axi_bresp <= `SKTF_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read path: one read in flight, data one cycle after the address is taken
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `SKTF_RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `SKTF_RESP_OKAY;
        s_axi_rdata <= 32'h0;
        if (reg_hit(s_axi_araddr) == 2'h1 && s_axi_araddr[1:0] == 2'h0) begin
          case (s_axi_araddr[3:0])
            `SKTF_OFS_INTCTL2: begin
              s_axi_rdata <= {28'h0, interrupt_control_second_q};
            end
            `SKTF_OFS_EXT0CTL: begin
              s_axi_rdata <= {28'h0, ext0_interrupt_control_q};
            end
            `SKTF_OFS_EXT1CTL: begin
              s_axi_rdata <= {28'h0, ext1_interrupt_control_q};
            end
            `SKTF_OFS_STATUS: begin
              s_axi_rdata <= {28'h0, status};
            end
            default: begin
              s_axi_rresp <= `SKTF_RESP_SLVERR;
            end
          endcase
        end else begin
          s_axi_rresp <= `SKTF_RESP_SLVERR;
        end
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // sktf_core

// *** verification/sktf_sva.sv ***
// assertions on the skip-test block instruction port
`timescale 1ns/1ns
`include "sktf_regs.vh"
module sktf_sva (
  input wire mclk,
  input wire sys_rst,
  input wire instr_valid,
  input wire [9:0] instr_word,
  input wire conv_done_set,
  input wire instr_done,
  input wire skip_next,
  input wire conversion_done_flag
);
  wire take = instr_valid && !skip_next;
  wire conv = take && instr_word == `SKTF_OP_CONV_DONE;
  wire pin = take && (instr_word == `SKTF_OP_EXT0_LEVEL || instr_word == `SKTF_OP_EXT1_LEVEL);
  wire flg = conversion_done_flag;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  a_done_one_cycle: assert property (conv || pin |=> instr_done) else $error("no done");
  a_other_no_done: assert property (!(conv || pin) |=> !instr_done) else $error("stray done");
  a_skip_clears_flag: assert property (conv && flg && !conv_done_set |=> skip_next != flg)
    else $error("flag skip");
  a_clear_no_skip: assert property (conv && !flg && !conv_done_set |=> !skip_next && !flg)
    else $error("empty skip");
  a_set_wins: assert property (conv_done_set |=> flg) else $error("flag not set");
  a_skip_drops: assert property (skip_next && instr_valid |=> !skip_next && !instr_done)
    else $error("skip not dropped");
  a_skip_holds: assert property (skip_next && !instr_valid |=> skip_next) else $error("skip lost");
  a_skip_cause: assert property ($rose(skip_next) |-> instr_done && $past(instr_valid))
    else $error("skip uncaused");
  c_conv_skip: cover property (conv && flg ##1 skip_next);
  c_pin_skip: cover property (pin ##1 skip_next);
  c_dropped: cover property (skip_next && instr_valid);
endmodule // sktf_sva
bind sktf_core sktf_sva i_sva (.mclk, .sys_rst, .instr_valid, .instr_word, .conv_done_set,
  .instr_done, .skip_next, .conversion_done_flag);

// *** verification/sktf_seq.sv ***
// sequencer model presenting one instruction word per call
`timescale 1ns/1ns
module sktf_seq (
  input wire mclk,
  output reg instr_valid,
  output reg [9:0] instr_word
);
  initial begin
    instr_valid = 1'b0;
    instr_word = 10'h000;
  end
  // word is scrambled once invalid so no stale code looks valid
  task issue(input [9:0] w);
    begin
      @(posedge mclk);
      instr_valid <= 1'b1;
      instr_word <= w;
      @(posedge mclk);
      instr_valid <= 1'b0;
      instr_word <= ~w;
    end
  endtask
endmodule // sktf_seq

// *** verification/skip_test_flag_and_pin_tb_top.sv ***
// bench for the skip-test block: register tasks and instruction scenarios
`timescale 1ns/1ns
`include "sktf_regs.vh"
module skip_test_flag_and_pin_tb_top;
  reg mclk, sys_rst, conv_done_set, pin0, pin1, awv, wv, bready, arv, rready;
  reg [31:0] addr, wdata, rd;
  reg [1:0] resp;
  wire [9:0] instr_word;
  wire [31:0] s_axi_rdata;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire instr_valid, instr_done, skip_next, flag, s_axi_awready, s_axi_wready;
  wire s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  integer failures, n_tests, p;
  sktf_seq i_seq (.mclk, .instr_valid, .instr_word);
  sktf_core i_dut (.mclk, .sys_rst, .instr_valid, .instr_word, .conv_done_set,
    .external_input_zero_pin(pin0), .external_input_one_pin(pin1), .instr_done, .skip_next,
    .conversion_done_flag(flag), .s_axi_awaddr(addr), .s_axi_awvalid(awv), .s_axi_awready,
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready(bready), .s_axi_araddr(addr), .s_axi_arvalid(arv),
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready(rready));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task chk(input string n, input [31:0] x, input [31:0] g);
    begin
      n_tests = n_tests + 1;
      if (x !== g) begin
        failures = failures + 1;
        $display("mismatch %s expected %h seen %h", n, x, g);
      end
    end
  endtask
  task wr(input [31:0] a, input [31:0] d);
    begin
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bready <= 1'b1;
      do begin
        @(posedge mclk);
        if (s_axi_awready) awv <= 1'b0;
        if (s_axi_wready) wv <= 1'b0;
      end while (!s_axi_bvalid);
      resp = s_axi_bresp;
      bready <= 1'b0;
    end
  endtask
  task rdr(input [31:0] a);
    begin
      @(posedge mclk);
      addr <= a;
      arv <= 1'b1;
      rready <= 1'b1;
      do begin
        @(posedge mclk);
        if (s_axi_arready) arv <= 1'b0;
      end while (!s_axi_rvalid);
      rd = s_axi_rdata;
      resp = s_axi_rresp;
      rready <= 1'b0;
    end
  endtask
  // one test instruction, then a filler word that a pending skip must swallow
  task tst(input [9:0] w, input s, input f);
    begin
      i_seq.issue(w);
      #1;
      chk("done", 1, instr_done);
      chk("skip", s, skip_next);
      chk("flag", f, flag);
      i_seq.issue(10'h000);
      #1;
      chk("drop", 0, skip_next);
    end
  endtask
  task complete_run;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  initial begin
    repeat (5000) @(posedge mclk);
    failures = failures + 1;
    complete_run;
  end
  initial begin
    {sys_rst, conv_done_set, pin0, pin1, awv, wv, bready, arv, rready} = 9'h100;
    {addr, wdata, failures, n_tests} = 0;
    repeat (4) @(posedge mclk);
    sys_rst <= 1'b0;
    rdr(`SKTF_OFS_INTCTL2);
    chk("ctl reset", 0, rd);
    rdr(32'h10);
    chk("unmapped", `SKTF_RESP_SLVERR, resp);
    $display("test bus done");
    // opposite polarities on the two controls expose a swapped bit source
    for (p = 0; p < 4; p = p + 1) begin
      wr(`SKTF_OFS_EXT0CTL, {29'h0, p[1], 2'h0});
      wr(`SKTF_OFS_EXT1CTL, {29'h0, !p[1], 2'h0});
      pin0 <= p[0];
      pin1 <= p[0];
      repeat (3) @(posedge mclk);
      tst(`SKTF_OP_EXT0_LEVEL, p[0] == p[1], 0);
      tst(`SKTF_OP_EXT1_LEVEL, p[0] != p[1], 0);
      // the status view shows the synchronised levels the tests above used
      rdr(`SKTF_OFS_STATUS);
      chk("pin sync", {2{p[0]}}, rd[2:1]);
    end
    $display("test pins done");
    wr(`SKTF_OFS_INTCTL2, 32'h4);
    @(posedge mclk);
    conv_done_set <= 1'b1;
    @(posedge mclk);
    conv_done_set <= 1'b0;
    tst(`SKTF_OP_CONV_DONE, 0, 1);
    wr(`SKTF_OFS_INTCTL2, 32'h0);
    tst(`SKTF_OP_CONV_DONE, 1, 0);
    tst(`SKTF_OP_CONV_DONE, 0, 0);
    rdr(`SKTF_OFS_STATUS);
    chk("status flag", 0, rd[0]);
    @(posedge mclk);
    conv_done_set <= 1'b1;
    @(posedge mclk);
    conv_done_set <= 1'b0;
    // a new completion landing in the skip cycle must survive the skip clear
    fork
      i_seq.issue(`SKTF_OP_CONV_DONE);
      begin
        @(posedge mclk);
        conv_done_set <= 1'b1;
        @(posedge mclk);
        conv_done_set <= 1'b0;
      end
    join
    #1;
    chk("set wins", 1, flag);
    chk("set skip", 1, skip_next);
    i_seq.issue(10'h000);
    #1;
    chk("set drop", 0, skip_next);
    wr(`SKTF_OFS_STATUS, 32'h1);
    chk("clear resp", `SKTF_RESP_OKAY, resp);
    rdr(`SKTF_OFS_STATUS);
    chk("sw clear", 0, rd[0]);
    wr(32'h10, 32'h4);
    chk("bad write", `SKTF_RESP_SLVERR, resp);
    rdr(`SKTF_OFS_INTCTL2);
    chk("no effect", 0, rd);
    $display("test conv done");
    complete_run;
  end
endmodule // skip_test_flag_and_pin_tb_top
